// ==== rtl/rx_out_params.svh ====
// Constants of the receive parallel output block
`ifndef RX_OUT_PARAMS_SVH
`define RX_OUT_PARAMS_SVH

`define RXO_CODE_W 10
`define RXO_CHAR_W 8
`define RXO_STAT_W 3
`define RXO_ENT_W 14
`define RXO_ENT_COMMA 13
`define RXO_ENT_STAT_HI 12
`define RXO_ENT_STAT_LO 10
`define RXO_FIFO_DEPTH 8
`define RXO_CNT_W 8

`define RXO_SRC_SEL_RST 1'b0
`define RXO_RATE_SEL_RST 1'b1
`define RXO_REF_HALF_RST 1'b0
`define RXO_BYPASS_RST 1'b0
`define RXO_CHAR_RST 8'h00
`define RXO_STAT_RST 3'h0

`endif

// ==== rtl/rx_out_pkg.sv ====
// Types of the receive parallel output block
package rx_out_pkg;

  typedef enum logic [2:0] {
    CK_IDLE = 3'b001,
    CK_HIGH = 3'b010,
    CK_LOW = 3'b100
  } clk_state_t;

endpackage

// ==== rtl/rx_parallel_out.sv ====
// Receive parallel output of one transceiver channel, with its character FIFO
// Operation
// - Character and status outputs change only on a tick of the selected interface clock.
// - The clock source select is a per-channel latch written through the configuration port.
// - Full-rate interface clock is a true and complement pair, one cycle per character.
// - In full-rate clocking outputs change on the true clock rise; the host takes one per period.
// - In half-rate clocking a new character comes on every rise and every fall of the clock.
// - With the decoder bypassed, the two low bits of the 10-bit character go on status bits 1:0.
// - With the decoder bypassed, status bit 2 is high while the presented character is a comma.
// - With the decoder enabled, all three status bits carry the encoded receive status.
// - The clock runs continuously at character or dual-character rate, per the rate select.
// - Rate follows the rate select for a full-rate reference, or half-rate with select 0.
// - With a half-rate reference and select 1, the clock runs at the reference frequency.
// - Select value 0 times the output from the recovered character clock.
// - With a half-rate reference, outputs timed from it follow both of its edges.
`timescale 1ns/1ps
`include "rx_out_params.svh"

module rx_out_fifo #(
  parameter int WIDTH = `RXO_ENT_W,
  parameter int DEPTH = `RXO_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic resetn_in,
  // Fill side
  input wire logic wr_valid_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  output logic wr_ready_out,
  // Drain side
  output logic rd_valid_out,
  output logic [WIDTH-1:0] rd_data_out,
  input wire logic rd_ready_in
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wptr_q, wptr_d, rptr_q, rptr_d;
  logic [AW:0] cnt_q, cnt_d;
  logic ready_q, ready_d;
  logic push, pop;

  assign push = wr_valid_in && ready_q;
  assign pop = rd_ready_in && (cnt_q != '0);
  assign wr_ready_out = ready_q;
  assign rd_valid_out = (cnt_q != '0);
  assign rd_data_out = mem_q[rptr_q];

  always_comb begin
    wptr_d = wptr_q;
    rptr_d = rptr_q;
    cnt_d = cnt_q;
    if (push) begin
      wptr_d = (wptr_q == LAST) ? '0 : wptr_q + 1'b1;
    end
    if (pop) begin
      rptr_d = (rptr_q == LAST) ? '0 : rptr_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
    // Registered ready so a full FIFO refuses the very next word
    ready_d = (cnt_d < (AW+1)'(DEPTH));
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q <= '0;
      ready_q <= 1'b0;
    end else begin
      wptr_q <= wptr_d;
      rptr_q <= rptr_d;
      cnt_q <= cnt_d;
      ready_q <= ready_d;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem_q[wptr_q] <= wr_data_in;
    end
  end
endmodule

module rx_parallel_out #(
  parameter int FIFO_DEPTH = `RXO_FIFO_DEPTH,
  parameter int CNT_W = `RXO_CNT_W
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic resetn_in,
  // Configuration latch write
  input wire logic cfg_wr_in,
  input wire logic cfg_src_sel_in,
  input wire logic cfg_rate_sel_in,
  input wire logic cfg_ref_half_in,
  input wire logic cfg_dec_bypass_in,
  // Timing sources
  input wire logic channel_ref_clk_in,
  input wire logic rec_char_tick_in,
  // Received characters
  input wire logic char_valid_in,
  input wire logic [`RXO_CODE_W-1:0] char_code_in,
  input wire logic char_comma_in,
  input wire logic [`RXO_STAT_W-1:0] char_stat_in,
  output logic char_ready_out,
  // Host side
  output logic [`RXO_CHAR_W-1:0] rx_char_out,
  output logic [`RXO_STAT_W-1:0] rx_status_out,
  output logic rx_iface_clk_out,
  output logic rx_iface_clk_n_out,
  // Latched settings
  output logic rx_clk_source_sel_out,
  output logic rx_clk_rate_sel_out
);
  // Rate select 1 is character rate (full), 0 is dual-character rate (half)
  function automatic logic half_mode(input logic rate, input logic src, input logic ref_half);
    half_mode = (ref_half && src) ? 1'b1 : !rate;
  endfunction

  logic src_q, src_d, rate_q, rate_d, refh_q, refh_d, byp_q, byp_d;
  logic ref_s1_q, ref_s2_q, ref_s3_q;
  logic tick, half, in_ready;
  logic fifo_valid;
  logic [`RXO_ENT_W-1:0] fifo_data;
  logic [`RXO_CHAR_W-1:0] char_q, char_d;
  logic [`RXO_STAT_W-1:0] stat_q, stat_d;
  logic clk_q, clk_d, clkn_q, clkn_d;
  logic [CNT_W-1:0] cnt_q, cnt_d, per_q, per_d;
  rx_out_pkg::clk_state_t st_q, st_d;

  // Settings are private to this instance, one per channel
  always_comb begin
    src_d = src_q;
    rate_d = rate_q;
    refh_d = refh_q;
    byp_d = byp_q;
    if (cfg_wr_in) begin
      src_d = cfg_src_sel_in;
      rate_d = cfg_rate_sel_in;
      refh_d = cfg_ref_half_in;
      byp_d = cfg_dec_bypass_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      src_q <= `RXO_SRC_SEL_RST;
      rate_q <= `RXO_RATE_SEL_RST;
      refh_q <= `RXO_REF_HALF_RST;
      byp_q <= `RXO_BYPASS_RST;
    end else begin
      src_q <= src_d;
      rate_q <= rate_d;
      refh_q <= refh_d;
      byp_q <= byp_d;
    end
  end

  // Reference pin is asynchronous: two stages, then an edge stage
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      ref_s1_q <= 1'b0;
      ref_s2_q <= 1'b0;
      ref_s3_q <= 1'b0;
    end else begin
      ref_s1_q <= channel_ref_clk_in;
      ref_s2_q <= ref_s1_q;
      ref_s3_q <= ref_s2_q;
    end
  end

  always_comb begin
    if (src_q) begin
      tick = refh_q ? (ref_s2_q ^ ref_s3_q) : (ref_s2_q && !ref_s3_q);
    end else begin
      tick = rec_char_tick_in;
    end
  end

  assign half = half_mode(rate_q, src_q, refh_q);

  rx_out_fifo #(
    .WIDTH(`RXO_ENT_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .wr_valid_in(char_valid_in),
    .wr_data_in({char_comma_in, char_stat_in, char_code_in}),
    .wr_ready_out(in_ready),
    .rd_valid_out(fifo_valid),
    .rd_data_out(fifo_data),
    .rd_ready_in(tick)
  );

  // Output register: loads only when the interface clock ticks
  always_comb begin
    char_d = char_q;
    stat_d = stat_q;
    if (tick && fifo_valid) begin
      if (byp_q) begin
        char_d = fifo_data[`RXO_CODE_W-1:2];
        stat_d = {fifo_data[`RXO_ENT_COMMA], fifo_data[1:0]};
      end else begin
        char_d = fifo_data[`RXO_CHAR_W-1:0];
        stat_d = fifo_data[`RXO_ENT_STAT_HI:`RXO_ENT_STAT_LO];
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      char_q <= `RXO_CHAR_RST;
      stat_q <= `RXO_STAT_RST;
    end else begin
      char_q <= char_d;
      stat_q <= stat_d;
    end
  end

  // Interface clock: rises with the data in full rate, toggles per tick in half rate.
  // Full-rate fall lands mid-period, from the last measured tick spacing.
  always_comb begin
    st_d = st_q;
    clk_d = clk_q;
    per_d = per_q;
    cnt_d = (cnt_q == '1) ? cnt_q : cnt_q + 1'b1;
    case (st_q)
      rx_out_pkg::CK_IDLE, rx_out_pkg::CK_HIGH, rx_out_pkg::CK_LOW: begin
        if (tick) begin
          // A saturated count means no earlier tick to measure: fall one cycle after the rise
          per_d = (cnt_q == '1) ? '0 : cnt_d;
          cnt_d = '0;
          if (half) begin
            clk_d = !clk_q;
          end else begin
            clk_d = 1'b1;
          end
          st_d = clk_d ? rx_out_pkg::CK_HIGH : rx_out_pkg::CK_LOW;
        end else if (st_q == rx_out_pkg::CK_HIGH && !half && cnt_d >= (per_q >> 1)) begin
          clk_d = 1'b0;
          st_d = rx_out_pkg::CK_LOW;
        end
      end
      default: begin
        st_d = rx_out_pkg::CK_IDLE;
        clk_d = 1'b0;
      end
    endcase
    // A new setting restarts the clock from low
    if (cfg_wr_in) begin
      st_d = rx_out_pkg::CK_IDLE;
      clk_d = 1'b0;
      cnt_d = '1;
    end
    clkn_d = !clk_d;
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      st_q <= rx_out_pkg::CK_IDLE;
      clk_q <= 1'b0;
      clkn_q <= 1'b1;
      cnt_q <= '1;
      per_q <= '0;
    end else begin
      st_q <= st_d;
      clk_q <= clk_d;
      clkn_q <= clkn_d;
      cnt_q <= cnt_d;
      per_q <= per_d;
    end
  end

  // Ready is the FIFO's own registered flag, so an offered word is never lost
  assign char_ready_out = in_ready;
  assign rx_char_out = char_q;
  assign rx_status_out = stat_q;
  assign rx_iface_clk_out = clk_q;
  assign rx_iface_clk_n_out = clkn_q;
  assign rx_clk_source_sel_out = src_q;
  assign rx_clk_rate_sel_out = rate_q;

  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!resetn_in);

  data_on_tick_a: assert property (
    ##1 $changed(rx_char_out) |-> $past(tick) && $past(fifo_valid))
    else $error("character output changed without a tick");
  cfg_latch_a: assert property (
    cfg_wr_in |=> rx_clk_source_sel_out == $past(cfg_src_sel_in)
      && rx_clk_rate_sel_out == $past(cfg_rate_sel_in))
    else $error("configuration latch not loaded");
  clk_pair_a: assert property (
    rx_iface_clk_n_out == !rx_iface_clk_out)
    else $error("clock pair not complementary");
  full_rise_a: assert property (
    tick && !half && !cfg_wr_in |=> $rose(rx_iface_clk_out) && $fell(rx_iface_clk_n_out))
    else $error("full-rate clock not high after tick");
  half_toggle_a: assert property (
    tick && half && !cfg_wr_in |=> rx_iface_clk_out != $past(rx_iface_clk_out))
    else $error("half-rate clock did not toggle on tick");
  bypass_bits_a: assert property (
    tick && fifo_valid && byp_q |=> rx_status_out[1:0] == $past(fifo_data[1:0])
      && rx_char_out == $past(fifo_data[`RXO_CODE_W-1:2]))
    else $error("bypassed character bits misplaced");
  comma_flag_a: assert property (
    tick && fifo_valid && byp_q |=> rx_status_out[2] == $past(fifo_data[`RXO_ENT_COMMA]))
    else $error("comma flag wrong");
  dec_status_a: assert property (
    tick && fifo_valid && !byp_q |=> rx_status_out
      == $past(fifo_data[`RXO_ENT_STAT_HI:`RXO_ENT_STAT_LO]))
    else $error("decoded status wrong");
  ref_both_a: assert property (
    src_q && refh_q && ref_s2_q != ref_s3_q |-> tick)
    else $error("half-rate reference edge missed");
  rec_src_a: assert property (
    !src_q |-> tick == rec_char_tick_in)
    else $error("recovered tick not used");

  full_rate_c: cover property (tick && !half ##[1:20] tick && !half);
  half_rate_c: cover property (tick && half && src_q && refh_q);
  bypass_comma_c: cover property (tick && fifo_valid && byp_q && fifo_data[`RXO_ENT_COMMA]);
  fifo_full_c: cover property (char_valid_in && !char_ready_out);
endmodule

// ==== verif/rx_host_model.sv ====
// Host model that captures characters on the receive interface clock
`timescale 1ns/1ps
module rx_host_model (
  // Clock and control
  input wire logic mclk_in,
  input wire logic clr_in,
  input wire logic half_in,
  // Device outputs
  input wire logic [7:0] char_in,
  input wire logic [2:0] stat_in,
  input wire logic clk_in,
  input wire logic clk_n_in
);
  logic [10:0] cap[$];
  int bad = 0;
  logic clk_q = 1'b0;
  logic [10:0] word_q = 11'h000;
  // Sampled at mclk so edges of the interface clock are seen with the data they carry
  always @(posedge mclk_in) begin
    if (clr_in) begin
      cap.delete();
    end else begin
      if (clk_in !== clk_q && (half_in || clk_in === 1'b1)) begin
        cap.push_back({char_in, stat_in});
      end
      if (clk_n_in !== ~clk_in) bad++;
      if ({char_in, stat_in} !== word_q && clk_in === clk_q) bad++;
    end
    clk_q <= clk_in;
    word_q <= {char_in, stat_in};
  end
endmodule

// ==== verif/rx_parallel_out_test.sv ====
// Self-checking bench for the receive parallel output block
`timescale 1ns/1ps
`include "rx_out_params.svh"
module rx_parallel_out_test;
  logic mclk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic cfg_wr = 1'b0, src = 1'b0, rate = 1'b1, refh = 1'b0, byp = 1'b0;
  logic ref_clk = 1'b0, tick = 1'b0, valid = 1'b0, comma = 1'b0, clr = 1'b1;
  logic [9:0] code = 10'h000;
  logic [2:0] stat = 3'h0;
  logic ready, clk_t, clk_c, src_o, rate_o;
  logic [7:0] rch;
  logic [2:0] rst;
  logic [10:0] exp_q[$];
  int err_total = 0;
  int num_checks = 0;

  initial forever #2.5 mclk_in = ~mclk_in;

  rx_parallel_out dut (.mclk_in(mclk_in), .resetn_in(resetn_in), .cfg_wr_in(cfg_wr),
    .cfg_src_sel_in(src), .cfg_rate_sel_in(rate), .cfg_ref_half_in(refh),
    .cfg_dec_bypass_in(byp), .channel_ref_clk_in(ref_clk), .rec_char_tick_in(tick),
    .char_valid_in(valid), .char_code_in(code), .char_comma_in(comma),
    .char_stat_in(stat), .char_ready_out(ready), .rx_char_out(rch), .rx_status_out(rst),
    .rx_iface_clk_out(clk_t), .rx_iface_clk_n_out(clk_c),
    .rx_clk_source_sel_out(src_o), .rx_clk_rate_sel_out(rate_o));

  // Half mode as the host must know it: a half-rate reference with source select 1 overrides the rate select
  rx_host_model host (.mclk_in(mclk_in), .clr_in(clr), .half_in((refh & src) | ~rate),
    .char_in(rch), .stat_in(rst), .clk_in(clk_t), .clk_n_in(clk_c));

  function automatic logic [10:0] exp_word(logic [9:0] c, logic k, logic [2:0] s, logic b);
    return b ? {c[9:2], k, c[1:0]} : {c[7:0], s};
  endfunction

  task automatic chk(input logic [10:0] got, input logic [10:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge mclk_in);
    #1;
  endtask

  task automatic stop_test();
    if (err_total == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Host stalls (no ticks) while the source offers words for 20 cycles, past the point where the buffer refuses
  task automatic fill();
    logic acc;
    code = 10'($urandom);
    comma = 1'($urandom);
    stat = 3'($urandom);
    valid = 1'b1;
    repeat (20) begin
      acc = ready;
      step(1);
      if (acc === 1'b1) begin
        exp_q.push_back(exp_word(code, comma, stat, byp));
        code = 10'($urandom);
        comma = 1'($urandom);
        stat = 3'($urandom);
      end
    end
    valid = 1'b0;
  endtask

  task automatic drain();
    repeat (8) begin
      if (!src) begin
        tick = 1'b1;
        step(1);
        tick = 1'b0;
        step(5);
      end else begin
        ref_clk = ~ref_clk;
        step(6);
        if (!refh) begin
          ref_clk = ~ref_clk;
          step(6);
        end
      end
    end
    step(4);
  endtask

  initial begin
    void'($urandom(61046));
    repeat (16) @(posedge mclk_in);
    #1 resetn_in = 1'b1;
    chk({rch, rst}, 11'h000, "reset outputs");
    chk({7'h00, clk_t, clk_c, src_o, rate_o}, 11'h005, "reset clock");
    // Every combination of source, reference half-rate and rate select
    for (int r = 0; r < 8; r++) begin
      {src, refh, rate} = 3'(r);
      byp = 1'($urandom);
      clr = 1'b1;
      cfg_wr = 1'b1;
      step(1);
      cfg_wr = 1'b0;
      step(2);
      chk({9'h000, src_o, rate_o}, {9'h000, src, rate}, "latched settings");
      chk({10'h000, clk_t}, 11'h000, "clock after config");
      clr = 1'b0;
      fill();
      chk(11'(exp_q.size()), 11'd8, "words accepted");
      chk({10'h000, ready}, 11'h000, "ready when full");
      drain();
      chk(11'(host.cap.size()), 11'd8, "captures");
      for (int i = 0; i < 8; i++) begin
        if (i < host.cap.size()) chk(host.cap[i], exp_q[i], "word");
      end
      exp_q.delete();
    end
    chk(11'(host.bad), 11'h000, "clock pair and output timing");
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge mclk_in);
    err_total++;
    stop_test();
  end
endmodule
